// *** verilog/sram_jtag_tap_port.sv ***
`timescale 1ns/1ps
// Functional notes
// - Sample inputs on rising, drive on falling
// - Mode input steers FSM; undriven reads one
// - Data input feeds selected register; undriven one
// - State plus instruction selects serial register
// - Output driven only in shift states
// - Five high mode edges enter reset
// - Power-up reset, idle without test clock
// - Standard boundary-scan sequencing and registers
// - Three-bit instruction, preset to identify
module sram_jtag_tap_port
    import tap_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              tck,
    input  wire logic              tms_in,
    input  wire logic              tms_oe_ext,
    input  wire logic              tdi_in,
    input  wire logic              tdi_oe_ext,
    input  wire logic [BSR_W-1:0]  pin_values,
    output logic                   tdo_out,
    output logic                   tdo_oe,
    output logic      [BSR_W-1:0]  bsr_drive,
    output logic                   outputs_hiz,
    output logic                   extest_active,
    output logic                   core_tap_in_reset,
    output logic      [IR_W-1:0]   core_instr
);

    // ------------------------------------------------------------
    // Pin conditioning: pull-ups make an undriven pin a one
    // ------------------------------------------------------------
    link_in_t pins;
    assign pins.mode = tms_oe_ext ? tms_in : 1'b1;
    assign pins.din  = tdi_oe_ext ? tdi_in : 1'b1;

    // Memory pins run on their own clock; capture sees them two test
    // clocks late, so they must stay steady around Capture-DR
    logic [BSR_W-1:0] pin_values_tck;

    tap_sync #(.W(BSR_W)) u_pin_sync (
        .clock  (tck),
        .arst_n (arst_n),
        .d      (pin_values),
        .q      (pin_values_tck)
    );

    // ------------------------------------------------------------
    // TAP state machine on the test clock
    // ------------------------------------------------------------
    // arst_n doubles as power-up reset; without tck nothing moves
    tap_state_t state_reg, state_next;
    logic [2:0] ones_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RESET:     state_next = pins.mode ? ST_RESET : ST_IDLE;
            ST_IDLE:      state_next = pins.mode ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR:    state_next = pins.mode ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR:    state_next = pins.mode ? ST_EXIT1_DR
                                                 : ST_SHIFT_DR;
            ST_SHIFT_DR:  state_next = pins.mode ? ST_EXIT1_DR
                                                 : ST_SHIFT_DR;
            ST_EXIT1_DR:  state_next = pins.mode ? ST_UPDATE_DR
                                                 : ST_PAUSE_DR;
            ST_PAUSE_DR:  state_next = pins.mode ? ST_EXIT2_DR
                                                 : ST_PAUSE_DR;
            ST_EXIT2_DR:  state_next = pins.mode ? ST_UPDATE_DR
                                                 : ST_SHIFT_DR;
            ST_UPDATE_DR: state_next = pins.mode ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR:    state_next = pins.mode ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR:    state_next = pins.mode ? ST_EXIT1_IR
                                                 : ST_SHIFT_IR;
            ST_SHIFT_IR:  state_next = pins.mode ? ST_EXIT1_IR
                                                 : ST_SHIFT_IR;
            ST_EXIT1_IR:  state_next = pins.mode ? ST_UPDATE_IR
                                                 : ST_PAUSE_IR;
            ST_PAUSE_IR:  state_next = pins.mode ? ST_EXIT2_IR
                                                 : ST_PAUSE_IR;
            ST_EXIT2_IR:  state_next = pins.mode ? ST_UPDATE_IR
                                                 : ST_SHIFT_IR;
            ST_UPDATE_IR: state_next = pins.mode ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // Redundant with the graph, but makes the five-edge escape
    // explicit regardless of where the machine started
    wire force_reset = pins.mode && (ones_reg == (RESET_ONES - 3'h1));
    // Reload on entry, so a test clock that stops right there still
    // leaves the identify instruction active
    wire goes_reset  = force_reset || (state_next == ST_RESET);

    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_RESET;
            ones_reg  <= 3'h0;
        end else begin
            state_reg <= force_reset ? ST_RESET : state_next;
            ones_reg  <= pins.mode ? ((ones_reg == RESET_ONES) ?
                         ones_reg : ones_reg + 3'h1) : 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Serial registers, rising edge
    // ------------------------------------------------------------
    logic [IR_W-1:0]  ir_shift_reg;
    logic [IR_W-1:0]  ir_reg;
    logic [ID_W-1:0]  id_reg;
    logic [BSR_W-1:0] bsr_reg;
    logic [BSR_W-1:0] bsr_upd_reg;
    logic             byp_reg;

    wire sel_bsr = (ir_reg == INS_EXTEST) || (ir_reg == INS_SAMPLE) ||
                   (ir_reg == INS_SAMPLE_Z);
    wire sel_id  = (ir_reg == INS_IDCODE);
    wire in_reset = (state_reg == ST_RESET);
    wire [IR_W-1:0] ir_cap_val = {1'b0, IR_CAPTURE[1:0]};

    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            ir_shift_reg <= IR_RESET;
            ir_reg       <= IR_RESET;
        end else if (goes_reset) begin
            ir_reg <= IR_RESET;
        end else begin
            unique case (state_reg)
                ST_RESET:     ir_reg <= IR_RESET;
                ST_CAP_IR:    ir_shift_reg <= ir_cap_val;
                ST_SHIFT_IR:  ir_shift_reg <= {pins.din,
                                  ir_shift_reg[IR_W-1:1]};
                ST_UPDATE_IR: ir_reg <= ir_shift_reg;
                default:      ir_reg <= ir_reg;
            endcase
        end
    end

    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            id_reg  <= ID_VALUE;
            bsr_reg <= '0;
            byp_reg <= 1'b0;
        end else if (state_reg == ST_CAP_DR) begin
            id_reg  <= ID_VALUE;
            bsr_reg <= pin_values_tck;
            byp_reg <= 1'b0;
        end else if (state_reg == ST_SHIFT_DR) begin
            if (sel_id)
                id_reg <= {pins.din, id_reg[ID_W-1:1]};
            else if (sel_bsr)
                bsr_reg <= {pins.din, bsr_reg[BSR_W-1:1]};
            else
                byp_reg <= pins.din;
        end
    end

    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            bsr_upd_reg <= '0;
        end else if (state_reg == ST_UPDATE_DR && sel_bsr) begin
            bsr_upd_reg <= bsr_reg;
        end
    end

    // ------------------------------------------------------------
    // Output launch on the falling edge
    // ------------------------------------------------------------
    wire dr_bit = sel_id ? id_reg[0] : (sel_bsr ? bsr_reg[0] : byp_reg);
    wire shifting = (state_reg == ST_SHIFT_DR) ||
                    (state_reg == ST_SHIFT_IR);
    wire tdo_bit = (state_reg == ST_SHIFT_IR) ? ir_shift_reg[0] : dr_bit;

    always_ff @(negedge tck or negedge arst_n) begin
        if (!arst_n) begin
            tdo_out       <= 1'b0;
            tdo_oe        <= 1'b0;
            bsr_drive     <= '0;
            outputs_hiz   <= 1'b0;
            extest_active <= 1'b0;
        end else begin
            tdo_out       <= tdo_bit;
            tdo_oe        <= shifting;
            bsr_drive     <= bsr_upd_reg;
            outputs_hiz   <= (ir_reg == INS_SAMPLE_Z);
            extest_active <= (ir_reg == INS_EXTEST);
        end
    end

    // ------------------------------------------------------------
    // Status into the core clock domain
    // ------------------------------------------------------------
    // Slow-changing levels; a multi-bit skew lasts one core cycle
    tap_status_t stat_tck;
    tap_status_t stat_core;
    assign stat_tck.in_reset = in_reset;
    assign stat_tck.instr    = ir_reg;

    tap_sync #(.W(IR_W + 1)) u_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (stat_tck),
        .q      (stat_core)
    );

    assign core_tap_in_reset = stat_core.in_reset;
    assign core_instr        = stat_core.instr;

endmodule

// *** shared/tap_pkg.sv ***
package tap_pkg;

    // ------------------------------------------------------------
    // TAP controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h2,
        ST_CAP_DR     = 4'h3,
        ST_SHIFT_DR   = 4'h4,
        ST_EXIT1_DR   = 4'h5,
        ST_PAUSE_DR   = 4'h6,
        ST_EXIT2_DR   = 4'h7,
        ST_UPDATE_DR  = 4'h8,
        ST_SEL_IR     = 4'h9,
        ST_CAP_IR     = 4'hA,
        ST_SHIFT_IR   = 4'hB,
        ST_EXIT1_IR   = 4'hC,
        ST_PAUSE_IR   = 4'hD,
        ST_EXIT2_IR   = 4'hE,
        ST_UPDATE_IR  = 4'hF
    } tap_state_t;

    // ------------------------------------------------------------
    // Instructions and register sizes
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 8;
    localparam logic [IR_W-1:0] INS_EXTEST   = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE   = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE   = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS   = 3'h7;
    localparam logic [IR_W-1:0] IR_RESET     = INS_IDCODE;
    localparam logic [IR_W-1:0] IR_CAPTURE   = 3'h1;
    localparam logic [1:0]      IR_CAP_MASK  = 2'h3;
    // Arbitrary neutral identity value, bit 0 set as required
    localparam logic [ID_W-1:0] ID_VALUE     = 32'h0000_0001;
    localparam logic [2:0]      RESET_ONES   = 3'h5;

    // Pins of the test link, sampled together
    typedef struct packed {
        logic mode;
        logic din;
    } link_in_t;

    // Status passed back to the core clock domain
    typedef struct packed {
        logic       in_reset;
        logic [2:0] instr;
    } tap_status_t;

endpackage

// *** verilog/tap_sync.sv ***
`timescale 1ns/1ps
module tap_sync
    import tap_pkg::*;
#(
    parameter int W = 4
) (
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ------------------------------------------------------------
    // Two-stage synchroniser, first stage read only by the second
    // ------------------------------------------------------------
    logic [W-1:0] meta_reg;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// *** dv/sram_jtag_tap_port_assertions.sv ***
`timescale 1ns/1ps
module tap_port_checker
    import tap_pkg::*;
(
    input wire logic             clock,
    input wire logic             arst_n,
    input wire logic             tck,
    input wire logic             tms_in,
    input wire logic             tms_oe_ext,
    input wire logic             tdi_in,
    input wire logic             tdi_oe_ext,
    input wire logic [BSR_W-1:0] pin_values,
    input wire logic             tdo_out,
    input wire logic             tdo_oe,
    input wire logic [BSR_W-1:0] bsr_drive,
    input wire logic             outputs_hiz,
    input wire logic             extest_active,
    input wire logic             core_tap_in_reset,
    input wire logic [IR_W-1:0]  core_instr
);
    logic       tms_eff;
    logic [1:0] at_rise_reg;
    // A released mode pin reads as one
    assign tms_eff = tms_in | ~tms_oe_ext;
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n)
            at_rise_reg <= 2'h0;
        else
            at_rise_reg <= {tdo_out, tdo_oe};
    end
    sequence five_high;
        tms_eff [*5];
    endsequence
    a_five_high: assert property (@(posedge tck)
        disable iff (!arst_n) five_high |=> !tdo_oe)
        else $error("five mode ones left output on");
    a_out_fall: assert property (@(negedge tck)
        disable iff (!arst_n) {tdo_out, tdo_oe} == at_rise_reg)
        else $error("output moved off the falling edge");
    a_shift_hold: assert property (@(posedge tck)
        disable iff (!arst_n) tdo_oe && !tms_eff |=> tdo_oe)
        else $error("left shift with mode low");
    a_shift_exit: assert property (@(posedge tck)
        disable iff (!arst_n) tdo_oe && tms_eff |=> !tdo_oe)
        else $error("stayed in shift with mode high");
    a_shift_entry: assert property (@(posedge tck)
        disable iff (!arst_n) $rose(tdo_oe) |-> !$past(tms_eff))
        else $error("output enabled without a shift entry");
    a_update_quiet: assert property (@(posedge tck)
        disable iff (!arst_n) tdo_oe |->
        $stable({bsr_drive, outputs_hiz, extest_active}))
        else $error("update value moved during shift");
    a_mode_excl: assert property (@(negedge tck)
        disable iff (!arst_n) !(outputs_hiz && extest_active))
        else $error("two boundary modes at once");
    a_ir_default: assert property (@(posedge clock)
        disable iff (!arst_n)
        core_tap_in_reset [*3] |-> core_instr == INS_IDCODE)
        else $error("reset state without identify instruction");
endmodule
bind sram_jtag_tap_port tap_port_checker tap_port_checker_i (
    .clock(clock), .arst_n(arst_n), .tck(tck), .tms_in(tms_in),
    .tms_oe_ext(tms_oe_ext), .tdi_in(tdi_in), .tdi_oe_ext(tdi_oe_ext),
    .pin_values(pin_values), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .bsr_drive(bsr_drive), .outputs_hiz(outputs_hiz),
    .extest_active(extest_active), .core_tap_in_reset(core_tap_in_reset),
    .core_instr(core_instr));

// *** dv/tap_tester.sv ***
`timescale 1ns/1ps
module tap_tester
    import tap_pkg::*;
(
    output logic      tck,
    output logic      tms_in,
    output logic      tms_oe_ext,
    output logic      tdi_in,
    output logic      tdi_oe_ext,
    input  wire logic tdo_out
);
    initial begin
        tck = 1'b0;
        {tms_in, tms_oe_ext, tdi_in, tdi_oe_ext} = 4'h0;
    end
    // The clock stands low between steps; released pins show the inverse
    task automatic step(input link_in_t v, input link_in_t en,
                        output logic q);
        tms_oe_ext = en.mode;
        tdi_oe_ext = en.din;
        tms_in = en.mode ? v.mode : ~tms_in;
        tdi_in = en.din ? v.din : ~tdi_in;
        #15 tck = 1'b1;
        q = tdo_out;
        #15 tck = 1'b0;
    endtask
    task automatic walk(input logic [7:0] m, input int n);
        logic q;
        for (int i = 0; i < n; i++) step({m[i], 1'b1}, 2'h3, q);
    endtask
    task automatic shift(input int n, input logic [63:0] d,
                         input logic fl, output logic [63:0] q);
        q = '0;
        for (int i = 0; i < n; i++) step({i == n - 1, d[i]}, {1'b1, ~fl}, q[i]);
    endtask
    task automatic reset_seq(input logic fl);
        logic q;
        for (int i = 0; i < 5; i++) step(2'h3, {~fl, 1'b1}, q);
    endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb
    import tap_pkg::*;
;
    logic              clock, arst_n, tck, tms_in, tms_oe_ext, tdi_in;
    logic              tdi_oe_ext, tdo_out, tdo_oe, outputs_hiz;
    logic              extest_active, core_tap_in_reset;
    logic [BSR_W-1:0]  pin_values, bsr_drive;
    logic [IR_W-1:0]   core_instr;
    logic [63:0]       got;
    int                num_errors = 0;
    int                checks_done = 0;
    sram_jtag_tap_port sram_jtag_tap_port_i (.clock(clock), .arst_n(arst_n),
        .tck(tck), .tms_in(tms_in), .tms_oe_ext(tms_oe_ext), .tdi_in(tdi_in),
        .tdi_oe_ext(tdi_oe_ext), .pin_values(pin_values), .tdo_out(tdo_out),
        .tdo_oe(tdo_oe), .bsr_drive(bsr_drive), .outputs_hiz(outputs_hiz),
        .extest_active(extest_active), .core_instr(core_instr),
        .core_tap_in_reset(core_tap_in_reset));
    tap_tester tap_tester_i (.tck(tck), .tms_in(tms_in), .tdi_in(tdi_in),
        .tms_oe_ext(tms_oe_ext), .tdi_oe_ext(tdi_oe_ext), .tdo_out(tdo_out));
    // ------------------------------------------------------------
    // Checking and scenarios
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] seen);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_idle();
        repeat (20) @(negedge clock);
        check("in_reset", 64'h1, core_tap_in_reset);
        check("instr", INS_IDCODE, core_instr);
        check("tdo_oe", 64'h0, tdo_oe);
    endtask
    task automatic t_id();
        tap_tester_i.reset_seq(1'b1);
        tap_tester_i.walk(8'h02, 4);
        tap_tester_i.shift(64, 64'h0, 1'b1, got);
        check("id_shift", {32'hFFFF_FFFF, ID_VALUE}, got);
        #1 check("oe_exit", 64'h0, tdo_oe);
    endtask
    task automatic t_ir(input logic [2:0] c);
        tap_tester_i.reset_seq(1'b0);
        tap_tester_i.walk(8'h06, 5);
        tap_tester_i.shift(3, {61'h0, c}, 1'b0, got);
        check("ir_capture", IR_CAPTURE[1:0], got[1:0]);
        tap_tester_i.walk(8'h01, 2);
        repeat (4) @(negedge clock);
        check("core_instr", c, core_instr);
        check("extest", c == INS_EXTEST, extest_active);
        check("hiz", c == INS_SAMPLE_Z, outputs_hiz);
        if (c == INS_BYPASS || c == 3'h3) begin
            tap_tester_i.walk(8'h01, 3);
            tap_tester_i.shift(4, 64'hB, 1'b0, got);
            check("bypass", 64'h6, got[3:0]);
        end
    endtask
    task automatic t_bsr();
        pin_values = 8'hA5;
        tap_tester_i.reset_seq(1'b0);
        tap_tester_i.walk(8'h06, 5);
        tap_tester_i.shift(3, {61'h0, INS_SAMPLE}, 1'b0, got);
        tap_tester_i.walk(8'h03, 4);
        tap_tester_i.shift(8, 64'h3C, 1'b0, got);
        check("bsr_capture", 64'hA5, got[7:0]);
        tap_tester_i.walk(8'h01, 2);
        #1 check("bsr_drive", 64'h3C, bsr_drive);
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Generous bound: the whole sequence needs well under 40 us
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
    initial begin
        arst_n = 1'b0;
        pin_values = 8'h00;
        repeat (6) @(negedge clock);
        tap_tester_i.walk(8'h01, 1);
        repeat (6) @(negedge clock);
        arst_n = 1'b1;
        t_idle();
        t_id();
        t_ir(INS_EXTEST);
        t_ir(INS_IDCODE);
        t_ir(INS_SAMPLE_Z);
        t_ir(INS_SAMPLE);
        t_ir(INS_BYPASS);
        t_ir(3'h3);
        t_bsr();
        finish_test();
    end
endmodule
